// ---- hdl/acg_pkg.sv ----
// Constants, register map and types for the converter sequencing block.
// Assumes an 8-bit register port, one 100 MHz clock and synchronous reset.
package acg_pkg;

  // Register byte addresses on the register port
  localparam logic [7:0] ACG_OFS_RES_LO  = 8'h00;
  localparam logic [7:0] ACG_OFS_RES_HI  = 8'h01;
  localparam logic [7:0] ACG_OFS_CFG     = 8'h02;
  localparam logic [7:0] ACG_OFS_CTL     = 8'h03;
  localparam logic [7:0] ACG_OFS_STAT    = 8'h04;
  localparam logic [7:0] ACG_OFS_MUX     = 8'h05;
  localparam logic [7:0] ACG_OFS_WLO_LO  = 8'h06;
  localparam logic [7:0] ACG_OFS_WLO_HI  = 8'h07;
  localparam logic [7:0] ACG_OFS_WHI_LO  = 8'h08;
  localparam logic [7:0] ACG_OFS_WHI_HI  = 8'h09;

  // Indirect gain register indices, written through the result pair
  localparam logic [7:0] ACG_GIDX_UPPER  = 8'h04;
  localparam logic [7:0] ACG_GIDX_LOWER  = 8'h07;
  localparam logic [7:0] ACG_GIDX_ADD    = 8'h08;

  // Field positions
  localparam int ACG_CFG_GAIN_ACC = 0;
  localparam int ACG_CFG_CNT_LSB  = 1;
  localparam int ACG_CTL_EN       = 0;
  localparam int ACG_CTL_BURST    = 1;
  localparam int ACG_CTL_TRIG_LSB = 2;
  localparam int ACG_CTL_START    = 4;
  localparam int ACG_CTL_WIN_IE   = 5;
  localparam int ACG_CTL_WIN_IN   = 6;
  localparam int ACG_CTL_DONE_IE  = 7;
  localparam int ACG_ST_DONE      = 0;
  localparam int ACG_ST_WIN       = 1;
  localparam int ACG_ST_BUSY      = 2;
  localparam int ACG_GADD_BIT     = 0;

  // Reset values
  localparam logic [7:0]  ACG_CFG_RST   = 8'h00;
  localparam logic [7:0]  ACG_CTL_RST   = 8'h00;
  localparam logic [7:0]  ACG_MUX_RST   = 8'h00;
  localparam logic [15:0] ACG_WLO_RST   = 16'h0000;
  localparam logic [15:0] ACG_WHI_RST   = 16'hFFFF;
  localparam logic [7:0]  ACG_GAIN_RST  = 8'h00;
  localparam logic [15:0] ACG_RES_RST   = 16'h0000;

  // Trigger sources
  localparam logic [1:0] ACG_TRIG_SW   = 2'h0;
  localparam logic [1:0] ACG_TRIG_TMR1 = 2'h1;
  localparam logic [1:0] ACG_TRIG_TMR2 = 2'h2;
  localparam logic [1:0] ACG_TRIG_PIN  = 2'h3;

  // Timing: 200 ksps gives a least sample period of 5000 ns
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SAMPLE_PERIOD_NS  = 5000;
  localparam int SAMPLE_PERIOD_CYC = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] ACG_SAMPLE_GAP = 9'(SAMPLE_PERIOD_CYC - 1);
  localparam int ACG_WAKE_CYC      = 4;

  typedef enum logic [2:0] {
    ACG_IDLE  = 3'b000,
    ACG_WAKE  = 3'b001,
    ACG_TRACK = 3'b010,
    ACG_WAIT  = 3'b011,
    ACG_FIN   = 3'b100
  } acg_state_e;

  // Accumulation count select: 1, 4, 8 or 16 samples
  function automatic logic [4:0] acg_count(input logic [1:0] sel);
    unique case (sel)
      2'h0: acg_count = 5'h01;
      2'h1: acg_count = 5'h04;
      2'h2: acg_count = 5'h08;
      2'h3: acg_count = 5'h10;
    endcase
  endfunction

endpackage

// ---- hdl/acg_acc_if.sv ----
// Carrier between the sequencer and its sample accumulator.
// Assumes both ends share clk and rst of the top module.
`timescale 1ns/10ps
interface acg_acc_if;
  logic        clr;
  logic        add;
  logic [11:0] smp;
  logic [15:0] sum;
  modport ctl (output clr, output add, output smp, input sum);
  modport acc (input clr, input add, input smp, output sum);
endinterface

// ---- hdl/acg_accum.sv ----
// Sample accumulator: clears on request, adds one 12-bit sample per strobe.
// Assumes clear and add never come in the same cycle; clear wins if they do.
`timescale 1ns/10ps
module acg_accum (
  input wire logic clk,
  input wire logic rst,
  acg_acc_if.acc   bus
);

  typedef struct packed {
    logic [15:0] sum;
  } acg_acc_s;

  acg_acc_s r_r;
  acg_acc_s r_nxt;

  always_comb begin
    r_nxt = r_r;
    if (bus.clr) begin
      r_nxt.sum = 16'h0000;
    end else if (bus.add) begin
      r_nxt.sum = r_r.sum + {4'h0, bus.smp};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign bus.sum = r_r.sum;

  ////////////////////////////////////////////////////////////////////////////
  clear_to_zero_a: assert property (@(posedge clk) disable iff (rst)
    bus.clr |=> bus.sum == 16'h0000) else $error("accumulator not cleared");
  sum_adds_sample_a: assert property (@(posedge clk) disable iff (rst)
    (bus.add && !bus.clr) |=> bus.sum == $past(bus.sum) + {4'h0, $past(bus.smp)})
    else $error("accumulator sum wrong");

endmodule

// ---- hdl/acg_ctrl.sv ----
// Converter sequencing, result, window and indirect gain register logic.
// Assumes a SAR core that answers each sample request with sample_valid.
//
// Summary of operation
// - Conversion starts on software, timer 1, timer 2 or pin, as selected.
// - Done flag and optional interrupt only after 1, 4, 8 or 16 samples.
// - Accumulated 12 to 16 bit sum is latched into the result pair.
// - Burst mode wakes the converter, samples, then shuts it down again.
// - Window interrupt only when result is inside, or outside, the limits.
// - Input select chooses pins, temperature sensor or supply, against ground.
// - Samples are spaced for at most 200 ksps.
// - Software can shut the converter down.
// - With gain access set, result pair writes go to gain registers.
// - High result write selects gain index, low result write stores data.
// - Gain registers are write-only; no read returns them.
// - Gain indices are 0x04 upper, 0x07 lower nibble, 0x08 add.
// - Gain is the 12-bit word over 4096, plus 1/64 when add bit set.
// - Lower gain register holds low four bits in its upper nibble.
`timescale 1ns/10ps
module acg_ctrl #(
  parameter int WAKE_CYC = acg_pkg::ACG_WAKE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        tmr1_ovf,
  input  wire logic        tmr2_ovf,
  input  wire logic        cnv_start,
  input  wire logic        sample_valid,
  input  wire logic [11:0] sample_data,
  output logic             sample_req,
  output logic             conv_power,
  output logic      [7:0]  input_sel,
  output logic      [11:0] gain_word,
  output logic             gain_add,
  output logic             irq
);

  typedef struct packed {
    acg_pkg::acg_state_e st;
    logic [8:0]          gap;
    logic [4:0]          left;
    logic [3:0]          wake;
    logic [15:0]         result;
    logic [7:0]          cfg;
    logic [7:0]          ctl;
    logic [7:0]          mux;
    logic [15:0]         wlo;
    logic [15:0]         whi;
    logic                done;
    logic                win;
    logic [7:0]          gidx;
    logic [7:0]          g_up;
    logic [7:0]          g_lo;
    logic [7:0]          g_add;
    logic [11:0]         g_app;
    logic                gadd_app;
    logic [7:0]          rdata;
    logic                irq;
    logic                req;
    logic                power;
    logic                pin_prev;
  } acg_ctrl_s;

  acg_ctrl_s   r_r;
  acg_ctrl_s   r_nxt;
  acg_acc_if   acc ();

  acg_accum u_accum (
    .clk (clk),
    .rst (rst),
    .bus (acc)
  );

  logic        trig;
  logic        gacc;
  logic        wr_clr_done;
  logic        wr_clr_win;
  logic        in_win;
  logic [15:0] wake_len;

  always_comb begin
    r_nxt       = r_r;
    acc.clr     = 1'b0;
    acc.add     = 1'b0;
    acc.smp     = sample_data;
    gacc        = r_r.cfg[acg_pkg::ACG_CFG_GAIN_ACC];
    wake_len    = 16'(WAKE_CYC - 1);
    in_win      = (acc.sum >= r_r.wlo) && (acc.sum <= r_r.whi);
    trig        = 1'b0;
    wr_clr_done = 1'b0;
    wr_clr_win  = 1'b0;
    r_nxt.req   = 1'b0;
    r_nxt.pin_prev = cnv_start;
    //////////////////////////////////////////////////////////////////////////
    // Trigger selection; the pin starts on its rising edge
    unique case (r_r.ctl[acg_pkg::ACG_CTL_TRIG_LSB +: 2])
      acg_pkg::ACG_TRIG_SW:   trig = reg_wr && reg_addr == acg_pkg::ACG_OFS_CTL
                                     && reg_wdata[acg_pkg::ACG_CTL_START];
      acg_pkg::ACG_TRIG_TMR1: trig = tmr1_ovf;
      acg_pkg::ACG_TRIG_TMR2: trig = tmr2_ovf;
      acg_pkg::ACG_TRIG_PIN:  trig = cnv_start && !r_r.pin_prev;
    endcase
    //////////////////////////////////////////////////////////////////////////
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        acg_pkg::ACG_OFS_RES_HI: if (gacc) r_nxt.gidx = reg_wdata;
        acg_pkg::ACG_OFS_RES_LO: if (gacc) begin
          if (r_r.gidx == acg_pkg::ACG_GIDX_UPPER) r_nxt.g_up = reg_wdata;
          if (r_r.gidx == acg_pkg::ACG_GIDX_LOWER) r_nxt.g_lo = reg_wdata;
          if (r_r.gidx == acg_pkg::ACG_GIDX_ADD)   r_nxt.g_add = reg_wdata;
        end
        acg_pkg::ACG_OFS_CFG:    r_nxt.cfg = reg_wdata;
        acg_pkg::ACG_OFS_CTL:    r_nxt.ctl = reg_wdata & ~(8'h01 << acg_pkg::ACG_CTL_START);
        acg_pkg::ACG_OFS_STAT: begin
          wr_clr_done = reg_wdata[acg_pkg::ACG_ST_DONE];
          wr_clr_win  = reg_wdata[acg_pkg::ACG_ST_WIN];
        end
        acg_pkg::ACG_OFS_MUX:    r_nxt.mux = reg_wdata;
        acg_pkg::ACG_OFS_WLO_LO: r_nxt.wlo[7:0]  = reg_wdata;
        acg_pkg::ACG_OFS_WLO_HI: r_nxt.wlo[15:8] = reg_wdata;
        acg_pkg::ACG_OFS_WHI_LO: r_nxt.whi[7:0]  = reg_wdata;
        acg_pkg::ACG_OFS_WHI_HI: r_nxt.whi[15:8] = reg_wdata;
        default: ;
      endcase
    end
    // Flags: write one clears, a same-cycle set below wins
    if (wr_clr_done) r_nxt.done = 1'b0;
    if (wr_clr_win)  r_nxt.win  = 1'b0;
    //////////////////////////////////////////////////////////////////////////
    // Sequencer
    if (r_r.gap != 9'h000) r_nxt.gap = r_r.gap - 9'h001;
    unique case (r_r.st)
      acg_pkg::ACG_IDLE: begin
        if (trig && (r_r.ctl[acg_pkg::ACG_CTL_EN] || r_r.ctl[acg_pkg::ACG_CTL_BURST])) begin
          acc.clr        = 1'b1;
          r_nxt.left     = acg_pkg::acg_count(r_r.cfg[acg_pkg::ACG_CFG_CNT_LSB +: 2]);
          r_nxt.g_app    = {r_r.g_up, r_r.g_lo[7:4]};
          r_nxt.gadd_app = r_r.g_add[acg_pkg::ACG_GADD_BIT];
          r_nxt.wake     = wake_len[3:0];
          r_nxt.st       = r_r.ctl[acg_pkg::ACG_CTL_EN] ? acg_pkg::ACG_TRACK : acg_pkg::ACG_WAKE;
        end
      end
      acg_pkg::ACG_WAKE: begin
        r_nxt.wake = r_r.wake - 4'h1;
        if (r_r.wake == 4'h0) r_nxt.st = acg_pkg::ACG_TRACK;
      end
      acg_pkg::ACG_TRACK: begin
        if (r_r.gap == 9'h000) begin
          r_nxt.req = 1'b1;
          r_nxt.gap = acg_pkg::ACG_SAMPLE_GAP;
          r_nxt.st  = acg_pkg::ACG_WAIT;
        end
      end
      acg_pkg::ACG_WAIT: begin
        if (sample_valid) begin
          acc.add    = 1'b1;
          r_nxt.left = r_r.left - 5'h01;
          r_nxt.st   = (r_r.left == 5'h01) ? acg_pkg::ACG_FIN : acg_pkg::ACG_TRACK;
        end
      end
      acg_pkg::ACG_FIN: begin
        r_nxt.result = acc.sum;
        r_nxt.done   = 1'b1;
        if (in_win == r_r.ctl[acg_pkg::ACG_CTL_WIN_IN]) r_nxt.win = 1'b1;
        r_nxt.st     = acg_pkg::ACG_IDLE;
      end
      default: r_nxt.st = acg_pkg::ACG_IDLE;
    endcase
    // Shut down unless enabled, or a conversion is in progress
    r_nxt.power = r_nxt.ctl[acg_pkg::ACG_CTL_EN] || (r_nxt.st != acg_pkg::ACG_IDLE);
    r_nxt.irq = (r_nxt.done && r_nxt.ctl[acg_pkg::ACG_CTL_DONE_IE])
             || (r_nxt.win && r_nxt.ctl[acg_pkg::ACG_CTL_WIN_IE]);
    //////////////////////////////////////////////////////////////////////////
    // Read path; gain registers have no read decode
    if (reg_rd) begin
      unique case (reg_addr)
        acg_pkg::ACG_OFS_RES_LO: r_nxt.rdata = r_r.result[7:0];
        acg_pkg::ACG_OFS_RES_HI: r_nxt.rdata = r_r.result[15:8];
        acg_pkg::ACG_OFS_CFG:    r_nxt.rdata = r_r.cfg;
        acg_pkg::ACG_OFS_CTL:    r_nxt.rdata = r_r.ctl;
        acg_pkg::ACG_OFS_STAT:   r_nxt.rdata = {5'h00, r_r.st != acg_pkg::ACG_IDLE, r_r.win, r_r.done};
        acg_pkg::ACG_OFS_MUX:    r_nxt.rdata = r_r.mux;
        acg_pkg::ACG_OFS_WLO_LO: r_nxt.rdata = r_r.wlo[7:0];
        acg_pkg::ACG_OFS_WLO_HI: r_nxt.rdata = r_r.wlo[15:8];
        acg_pkg::ACG_OFS_WHI_LO: r_nxt.rdata = r_r.whi[7:0];
        acg_pkg::ACG_OFS_WHI_HI: r_nxt.rdata = r_r.whi[15:8];
        default:                 r_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_r        <= '0;
      r_r.st     <= acg_pkg::ACG_IDLE;
      r_r.cfg    <= acg_pkg::ACG_CFG_RST;
      r_r.ctl    <= acg_pkg::ACG_CTL_RST;
      r_r.mux    <= acg_pkg::ACG_MUX_RST;
      r_r.wlo    <= acg_pkg::ACG_WLO_RST;
      r_r.whi    <= acg_pkg::ACG_WHI_RST;
      r_r.result <= acg_pkg::ACG_RES_RST;
      r_r.g_up   <= acg_pkg::ACG_GAIN_RST;
      r_r.g_lo   <= acg_pkg::ACG_GAIN_RST;
      r_r.g_add  <= acg_pkg::ACG_GAIN_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign reg_rdata  = r_r.rdata;
  assign sample_req = r_r.req;
  assign conv_power = r_r.power;
  assign input_sel  = r_r.mux;
  assign gain_word  = r_r.g_app;
  assign gain_add   = r_r.gadd_app;
  assign irq        = r_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks; spacing helper counts cycles since the last sample request
  logic [9:0] since_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      since_r <= 10'h3FF;
    end else if (r_r.req) begin
      since_r <= 10'h001;
    end else if (since_r != 10'h3FF) begin
      since_r <= since_r + 10'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sample_spacing_a: assert property (r_r.req |-> since_r >= 10'(acg_pkg::SAMPLE_PERIOD_CYC))
    else $error("samples spaced too closely");
  done_cause_a: assert property ($rose(r_r.done) |-> $past(r_r.st) == acg_pkg::ACG_FIN)
    else $error("done set outside completion");
  result_latch_a: assert property ($rose(r_r.done) |-> r_r.result == acc.sum)
    else $error("result not latched");
  gain_index_a: assert property (reg_wr && gacc && reg_addr == acg_pkg::ACG_OFS_RES_HI
    |=> r_r.gidx == $past(reg_wdata)) else $error("gain index not stored");
  gain_upper_a: assert property (reg_wr && gacc && reg_addr == acg_pkg::ACG_OFS_RES_LO
    && r_r.gidx == acg_pkg::ACG_GIDX_UPPER |=> r_r.g_up == $past(reg_wdata))
    else $error("upper gain not stored");
  result_read_a: assert property (reg_rd && reg_addr == acg_pkg::ACG_OFS_RES_LO
    |=> reg_rdata == $past(r_r.result[7:0])) else $error("result read wrong");
  gain_apply_a: assert property ($changed(gain_word) |-> $past(r_r.st) == acg_pkg::ACG_IDLE
    && $past(acc.clr)) else $error("gain changed mid conversion");
  power_off_a: assert property (!conv_power |-> r_r.st == acg_pkg::ACG_IDLE)
    else $error("power dropped during conversion");
  window_cause_a: assert property ($rose(r_r.win) |-> $past(r_r.st) == acg_pkg::ACG_FIN)
    else $error("window flag outside completion");
  burst_wake_a: assert property (r_r.st == acg_pkg::ACG_WAKE |-> conv_power ##1
    conv_power) else $error("burst not powered");

endmodule

// ---- tb/test_adc_conversion_gain_control.sv ----
// Self-checking bench for the converter sequencing and gain block.
// Assumes the bench stands in for the SAR core, both timers and the pin.
`timescale 1ns/10ps
module test_adc_conversion_gain_control;
  logic        clk          = 1'b0;
  logic        rst          = 1'b1;
  logic [7:0]  reg_addr     = 8'h00;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic [7:0]  reg_wdata    = 8'h00;
  logic [7:0]  reg_rdata;
  logic        tmr1_ovf     = 1'b0;
  logic        tmr2_ovf     = 1'b0;
  logic        cnv_start    = 1'b0;
  logic        sample_valid = 1'b0;
  logic [11:0] sample_data  = 12'h000;
  logic        sample_req;
  logic        conv_power;
  logic [7:0]  input_sel;
  logic [11:0] gain_word;
  logic        gain_add;
  logic        irq;
  int          error_cnt    = 0;
  int          n_compared   = 0;
  int          cyc          = 0;
  int          n_req        = 0;
  int          last_req     = 0;
  int          smp_idx      = 0;
  int          rsp_cnt      = 0;
  logic [11:0] tab [4]      = '{12'hFFF, 12'h800, 12'h001, 12'h123};

  acg_ctrl dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tmr1_ovf(tmr1_ovf), .tmr2_ovf(tmr2_ovf),
    .cnv_start(cnv_start), .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_req(sample_req), .conv_power(conv_power), .input_sel(input_sel),
    .gain_word(gain_word), .gain_add(gain_add), .irq(irq));

  initial begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask

  // Polls status; bounded at 10000 reads so a stuck sequencer ends in a failed done flag check
  task automatic wait_done();
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 10000 && s[0] !== 1'b1; k++) rd(acg_pkg::ACG_OFS_STAT, s);
    chk("done flag", {15'h0000, s[0]}, 16'h0001);
    chk("busy flag", {15'h0000, s[2]}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout; a hung sequencer ends here as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // SAR stand-in: answers each request three cycles later, garbage otherwise
  always @(posedge clk) begin
    if (sample_req === 1'b1) begin
      if (n_req > 0) chk("sample gap", 16'(cyc - last_req >= acg_pkg::SAMPLE_PERIOD_CYC), 16'h0001);
      chk("power at request", {15'h0000, conv_power}, 16'h0001);
      n_req    <= n_req + 1;
      last_req <= cyc;
      rsp_cnt  <= 3;
    end else if (rsp_cnt > 0) begin
      rsp_cnt <= rsp_cnt - 1;
    end
    if (rsp_cnt == 1) begin
      sample_valid <= 1'b1;
      sample_data  <= tab[smp_idx % 4];
      smp_idx      <= smp_idx + 1;
    end else begin
      sample_valid <= 1'b0;
      sample_data  <= ~sample_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [15:0] exp;
    logic [7:0]  b;
    logic [15:0] ns [4];
    logic [7:0]  gp [8];
    ns = '{16'h0001, 16'h0004, 16'h0008, 16'h0010};
    gp = '{acg_pkg::ACG_GIDX_UPPER, 8'h6C, acg_pkg::ACG_GIDX_LOWER, 8'hA0, acg_pkg::ACG_GIDX_ADD, 8'h01, 8'h09, 8'h00};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd16(acg_pkg::ACG_OFS_WHI_LO, v);
    chk("window high reset", v, acg_pkg::ACG_WHI_RST);
    rd16(acg_pkg::ACG_OFS_RES_LO, v);
    chk("result reset", v, acg_pkg::ACG_RES_RST);
    rd(8'h0A, b);
    chk("unmapped read", {8'h00, b}, 16'h0000);
    chk("power after reset", {15'h0000, conv_power}, 16'h0000);
    // Result pair is read-only while gain access is off
    wr(acg_pkg::ACG_OFS_RES_LO, 8'h55);
    rd16(acg_pkg::ACG_OFS_RES_LO, v);
    chk("result write ignored", v, 16'h0000);
    wr(acg_pkg::ACG_OFS_CFG, 8'h01);
    for (int k = 0; k < 8; k += 2) begin
      wr(acg_pkg::ACG_OFS_RES_HI, gp[k]);
      wr(acg_pkg::ACG_OFS_RES_LO, gp[k + 1]);
    end
    rd(acg_pkg::ACG_OFS_RES_LO, b);
    chk("gain not readable", {8'h00, b}, 16'h0000);
    wr(acg_pkg::ACG_OFS_CFG, 8'h00);
    chk("gain before start", {4'h0, gain_word}, 16'h0000);
    wr(acg_pkg::ACG_OFS_MUX, 8'h0B);
    wr(acg_pkg::ACG_OFS_WLO_LO, 8'hFF);
    wr(acg_pkg::ACG_OFS_WLO_HI, 8'h0F);
    wr(acg_pkg::ACG_OFS_WHI_LO, 8'h23);
    wr(acg_pkg::ACG_OFS_WHI_HI, 8'h19);
    chk("input select", {8'h00, input_sel}, 16'h000B);
    // Trigger i with count code i; window set to the 1- and 4-sample sums
    for (int i = 0; i < 4; i++) begin
      wr(acg_pkg::ACG_OFS_CFG, 8'(i << 1));
      wr(acg_pkg::ACG_OFS_CTL, 8'hC1 | 8'(i << 2));
      n_req = 0;
      smp_idx = 0;
      tmr1_ovf  <= (i != 1);
      tmr2_ovf  <= (i != 2);
      cnv_start <= (i != 3);
      @(posedge clk);
      {tmr1_ovf, tmr2_ovf, cnv_start} <= 3'b000;
      repeat (6) @(posedge clk);
      chk("foreign trigger", 16'(n_req), 16'h0000);
      tmr1_ovf  <= (i == 1);
      tmr2_ovf  <= (i == 2);
      cnv_start <= (i == 3);
      @(posedge clk);
      {tmr1_ovf, tmr2_ovf, cnv_start} <= 3'b000;
      if (i == 0) wr(acg_pkg::ACG_OFS_CTL, 8'hD1);
      repeat (3) @(posedge clk);
      #1 chk("gain word", {4'h0, gain_word}, 16'h06CA);
      chk("gain add", {15'h0000, gain_add}, 16'h0001);
      wait_done();
      chk("sample count", 16'(n_req), ns[i]);
      exp = 16'h0000;
      for (int j = 0; j < ns[i]; j++) exp += 16'(tab[j % 4]);
      rd16(acg_pkg::ACG_OFS_RES_LO, v);
      chk("result", v, exp);
      chk("done irq", {15'h0000, irq}, 16'h0001);
      rd(acg_pkg::ACG_OFS_STAT, b);
      chk("window flag", {15'h0000, b[1]}, 16'(exp >= 16'h0FFF && exp <= 16'h1923));
      wr(acg_pkg::ACG_OFS_STAT, 8'h03);
      rd(acg_pkg::ACG_OFS_STAT, b);
      chk("irq cleared", {15'h0000, irq}, 16'h0000);
    end
    // Disabled converter ignores a start and stays shut down
    wr(acg_pkg::ACG_OFS_CTL, 8'h00);
    n_req = 0;
    wr(acg_pkg::ACG_OFS_CTL, 8'h10);
    repeat (20) @(posedge clk);
    chk("disabled start", 16'(n_req), 16'h0000);
    chk("shutdown power", {15'h0000, conv_power}, 16'h0000);
    // Burst, outside-window interrupt on a result inside the window
    wr(acg_pkg::ACG_OFS_CFG, 8'h00);
    n_req = 0;
    smp_idx = 0;
    // Start is judged against the stored burst bit, so set it first
    wr(acg_pkg::ACG_OFS_CTL, 8'h22);
    wr(acg_pkg::ACG_OFS_CTL, 8'h32);
    wait_done();
    chk("burst samples", 16'(n_req), 16'h0001);
    chk("burst power off", {15'h0000, conv_power}, 16'h0000);
    chk("no window irq", {15'h0000, irq}, 16'h0000);
    rd16(acg_pkg::ACG_OFS_RES_LO, v);
    chk("burst result", v, 16'h0FFF);
    wrap_up();
  end
endmodule
